// *** cci_config.sv ***
`timescale 1ns/100ps
`include "cci_consts.svh"
module cci_config #(
    parameter int unsigned WDOG_LONG_CYC = `CCI_WDOG_LONG_CYC,
    parameter int unsigned WDOG_SHORT_CYC = `CCI_WDOG_SHORT_CYC,
    parameter int unsigned RECOV_HALF_CYC = `CCI_RECOV_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic reg_wr_en,
    input wire logic reg_wr_remote,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_wr_rejected,
    input wire logic fwd_seq_err_det,
    input wire logic remote_serializer_identifier_load,
    input wire cci_pkg::cci_i2c_addr_t remote_serializer_identifier_in,
    input wire logic xact_addr_valid,
    input wire cci_pkg::cci_i2c_addr_t xact_addr,
    output logic cc_addr_valid,
    output cci_pkg::cci_i2c_addr_t cc_addr,
    input wire logic sda_drive_req,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    output logic bus_free,
    output logic bus_recovering
);
    import cci_pkg::*;

    localparam int CNT_W = 25;
    localparam logic [CNT_W-1:0] LONG_M1 = CNT_W'(WDOG_LONG_CYC - 1);
    localparam logic [CNT_W-1:0] SHORT_M1 = CNT_W'(WDOG_SHORT_CYC - 1);
    localparam logic [CNT_W-1:0] HALF_M1 = CNT_W'(RECOV_HALF_CYC - 1);
    localparam logic [2:0] TAP_BASE = 3'(`CCI_SDA_BASE_CYC - 1);

    logic [6:0] ctl_reg;
    logic seq_err_reg;
    logic [6:0] rid_reg;
    logic freeze_reg;
    logic [7:0] rdata_reg;
    logic rej_reg;
    logic ccv_reg;
    cci_i2c_addr_t cca_reg;
    logic [7:0] dly_reg;
    logic sda_s1, sda_s2, sda_q, scl_s1, scl_s2, scl_q;
    cci_wdog_state_e wd_state_reg, wd_state_next;
    logic [CNT_W-1:0] wd_cnt_reg, wd_cnt_next;
    logic [3:0] pulse_reg, pulse_next;
    logic scl_oe_reg, scl_oe_next;
    cci_i2c_addr_t alias0, alias1, phys0, phys1;
    logic hit0, hit1;

    // Write decode.
    wire wr_block = reg_wr_en & reg_wr_remote & ctl_reg[`CCI_CTL2_LWD];
    wire wr_ok = reg_wr_en & ~wr_block;
    wire wr_ctl = wr_ok & (reg_addr == `CCI_OFS_CTL2);
    wire wr_rid = wr_ok & (reg_addr == `CCI_OFS_RID);
    wire wr_phys0 = wr_ok & (reg_addr == `CCI_OFS_PHYS0);
    wire wr_phys1 = wr_ok & (reg_addr == `CCI_OFS_PHYS1);
    wire wr_alias0 = wr_ok & (reg_addr == `CCI_OFS_ALIAS0);
    wire wr_alias1 = wr_ok & (reg_addr == `CCI_OFS_ALIAS1);
    wire freeze_next = wr_rid ? reg_wdata[`CCI_RID_FREEZE] : freeze_reg;
    wire [1:0] dly_field = ctl_reg[`CCI_CTL2_DLY_HI:`CCI_CTL2_DLY_LO];
    wire wd_dis = ctl_reg[`CCI_CTL2_WD_DIS];
    wire speedup = ctl_reg[`CCI_CTL2_SPEEDUP];

    wire seq_err_next = fwd_seq_err_det | (seq_err_reg & ~ctl_reg[`CCI_CTL2_SEQ_CLR]);

    wire [6:0] rid_next = !freeze_next ? (remote_serializer_identifier_load ? remote_serializer_identifier_in : rid_reg)
                        : (wr_rid ? reg_wdata[7:1] : rid_reg);

    wire [7:0] ctl_rd = {seq_err_reg, ctl_reg[6], 1'b0, ctl_reg[4:0]};
    wire [7:0] rd_mux = (reg_addr == `CCI_OFS_CTL2) ? ctl_rd :
                        (reg_addr == `CCI_OFS_RID) ? {rid_reg, freeze_reg} :
                        (reg_addr == `CCI_OFS_PHYS0) ? {phys0, 1'b0} :
                        (reg_addr == `CCI_OFS_PHYS1) ? {phys1, 1'b0} :
                        (reg_addr == `CCI_OFS_ALIAS0) ? {alias0, 1'b0} :
                        (reg_addr == `CCI_OFS_ALIAS1) ? {alias1, 1'b0} : 8'h00;

    wire cci_i2c_addr_t remap_addr = hit0 ? phys0 : (hit1 ? phys1 : xact_addr);

    wire [2:0] sda_tap = TAP_BASE + 3'(dly_field);

    wire activity = (sda_s2 ^ sda_q) | (scl_s2 ^ scl_q);
    wire [CNT_W-1:0] period_m1 = speedup ? SHORT_M1 : LONG_M1;
    wire half_done = (wd_cnt_reg == HALF_M1);

    cci_remap_entry u_entry0 (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .wr_alias(wr_alias0),
        .wr_phys(wr_phys0),
        .wdata(reg_wdata[7:1]),
        .xact_addr(xact_addr),
        .alias_addr(alias0),
        .phys_addr(phys0),
        .hit(hit0)
    );

    cci_remap_entry u_entry1 (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .wr_alias(wr_alias1),
        .wr_phys(wr_phys1),
        .wdata(reg_wdata[7:1]),
        .xact_addr(xact_addr),
        .alias_addr(alias1),
        .phys_addr(phys1),
        .hit(hit1)
    );

    always_comb begin
        wd_state_next = wd_state_reg;
        wd_cnt_next = wd_cnt_reg + CNT_W'(1);
        pulse_next = pulse_reg;
        scl_oe_next = scl_oe_reg;
        case (wd_state_reg)
            CCI_WD_WATCH: begin
                if (wd_dis || activity) begin
                    wd_cnt_next = '0;
                end else if (wd_cnt_reg == period_m1) begin
                    wd_cnt_next = '0;
                    if (sda_s2) begin
                        wd_state_next = CCI_WD_FREE;
                    end else begin
                        wd_state_next = CCI_WD_RECOVER;
                        scl_oe_next = 1'b1;
                        pulse_next = 4'h1;
                    end
                end
            end
            CCI_WD_FREE: begin
                wd_cnt_next = '0;
                if (wd_dis || activity) begin
                    wd_state_next = CCI_WD_WATCH;
                end
            end
            CCI_WD_RECOVER: begin
                if (wd_dis) begin
                    wd_state_next = CCI_WD_WATCH;
                    wd_cnt_next = '0;
                    scl_oe_next = 1'b0;
                end else if (half_done) begin
                    wd_cnt_next = '0;
                    if (scl_oe_reg) begin
                        scl_oe_next = 1'b0;
                    end else if (pulse_reg == `CCI_RECOV_PULSES) begin
                        wd_state_next = CCI_WD_WATCH;
                    end else begin
                        scl_oe_next = 1'b1;
                        pulse_next = pulse_reg + 4'h1;
                    end
                end
            end
            default: begin
                wd_state_next = CCI_WD_WATCH;
                wd_cnt_next = '0;
                scl_oe_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctl_reg <= 7'(`CCI_CTL2_RST);
            seq_err_reg <= 1'b0;
            rid_reg <= 7'(`CCI_RID_RST >> 1);
            freeze_reg <= 1'b0;
        end else begin
            if (wr_ctl) begin
                ctl_reg <= reg_wdata[6:0] & 7'(`CCI_CTL2_WMASK);
            end
            seq_err_reg <= seq_err_next;
            rid_reg <= rid_next;
            freeze_reg <= freeze_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
            rej_reg <= 1'b0;
            ccv_reg <= 1'b0;
            cca_reg <= `CCI_ADDR_RST;
            dly_reg <= 8'h00;
        end else begin
            rdata_reg <= reg_rd_en ? rd_mux : rdata_reg;
            rej_reg <= wr_block;
            ccv_reg <= xact_addr_valid;
            cca_reg <= xact_addr_valid ? remap_addr : cca_reg;
            dly_reg <= {dly_reg[6:0], sda_drive_req};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            {sda_s1, sda_s2, sda_q} <= 3'b111;
            {scl_s1, scl_s2, scl_q} <= 3'b111;
            wd_state_reg <= CCI_WD_WATCH;
            wd_cnt_reg <= '0;
            pulse_reg <= 4'h0;
            scl_oe_reg <= 1'b0;
        end else begin
            {sda_s1, sda_s2, sda_q} <= {sda_in, sda_s1, sda_s2};
            {scl_s1, scl_s2, scl_q} <= {scl_in, scl_s1, scl_s2};
            wd_state_reg <= wd_state_next;
            wd_cnt_reg <= wd_cnt_next;
            pulse_reg <= pulse_next;
            scl_oe_reg <= scl_oe_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_wr_rejected = rej_reg;
    assign cc_addr_valid = ccv_reg;
    assign cc_addr = cca_reg;
    assign sda_out = 1'b0;
    assign sda_oe = dly_reg[sda_tap];
    assign scl_out = 1'b0;
    assign scl_oe = scl_oe_reg;
    assign bus_free = (wd_state_reg == CCI_WD_FREE);
    assign bus_recovering = (wd_state_reg == CCI_WD_RECOVER);

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    sequence s_req_rise_dly0;
        $rose(sda_drive_req) ##0 (dly_field == 2'b00) [*6];
    endsequence
    sequence s_req_rise_dly3;
        ($rose(sda_drive_req) && dly_field == 2'b11) ##1 (dly_field == 2'b11) [*8];
    endsequence

    AST_SEQ_SET: assert property (fwd_seq_err_det |=> seq_err_reg)
        else $error("Sequence error not flagged.");
    AST_SEQ_CLR: assert property (ctl_reg[`CCI_CTL2_SEQ_CLR] && !fwd_seq_err_det |=> !seq_err_reg)
        else $error("Sequence error not cleared.");
    AST_SDA_DLY_MIN: assert property (s_req_rise_dly0 |-> $rose(sda_oe))
        else $error("SDA delay of 250 ns wrong.");
    AST_SDA_DLY_MAX: assert property (s_req_rise_dly3 |-> $rose(sda_oe))
        else $error("SDA delay of 400 ns wrong.");
    AST_LWD_BLOCK: assert property (wr_block |=> reg_wr_rejected && $stable(ctl_reg) && $stable(phys0))
        else $error("Remote write not blocked.");
    AST_WDOG_SHORT: assert property (speedup && $rose(bus_free) |-> $past(wd_cnt_reg) == SHORT_M1)
        else $error("Short watchdog period wrong.");
    AST_WDOG_OFF: assert property (wd_dis |=> wd_cnt_reg == '0 && !bus_recovering)
        else $error("Watchdog runs while disabled.");
    AST_FREE: assert property ($rose(bus_free) |-> $past(sda_s2) && $past(wd_cnt_reg) == $past(period_m1))
        else $error("Bus free without idle high SDA.");
    AST_RECOV: assert property ($rose(bus_recovering) |-> !$past(sda_s2) && scl_oe && pulse_reg == 4'h1)
        else $error("Recovery start wrong.");
    AST_RECOV_MAX: assert property (bus_recovering |-> pulse_reg <= `CCI_RECOV_PULSES)
        else $error("Too many recovery clocks.");
    AST_ID_AUTO: assert property (!freeze_next && remote_serializer_identifier_load |=> rid_reg == $past(remote_serializer_identifier_in))
        else $error("Remote identifier not loaded.");
    AST_ID_FROZEN: assert property (freeze_reg && !wr_rid |=> $stable(rid_reg))
        else $error("Frozen identifier changed.");
    AST_REMAP: assert property (xact_addr_valid && hit0 |=> cc_addr_valid && cc_addr == $past(phys0))
        else $error("Entry 0 remap wrong.");
    AST_RSVD: assert property (reg_rd_en && reg_addr == `CCI_OFS_CTL2 |=> reg_rdata[5] == 1'b0)
        else $error("Reserved bit reads nonzero.");
endmodule

// *** cci_consts.svh ***
`ifndef CCI_CONSTS_SVH
`define CCI_CONSTS_SVH

// Register offsets.
`define CCI_OFS_CTL2 8'h06
`define CCI_OFS_RID 8'h07
`define CCI_OFS_PHYS0 8'h08
`define CCI_OFS_PHYS1 8'h09
`define CCI_OFS_ALIAS0 8'h10
`define CCI_OFS_ALIAS1 8'h11

// Field positions in i2c_control_two.
`define CCI_CTL2_SEQ_ERR 7
`define CCI_CTL2_SEQ_CLR 6
`define CCI_CTL2_DLY_HI 4
`define CCI_CTL2_DLY_LO 3
`define CCI_CTL2_LWD 2
`define CCI_CTL2_SPEEDUP 1
`define CCI_CTL2_WD_DIS 0
`define CCI_CTL2_WMASK 8'h5F

// Field position of the freeze bit in remote_serializer_identifier.
`define CCI_RID_FREEZE 0

// Reset values.
`define CCI_CTL2_RST 8'h00
`define CCI_RID_RST 8'h00
`define CCI_ADDR_RST 7'h00

// Timing.
`define CCI_CLK_PERIOD_NS 50
`define CCI_CLK_HZ 20000000
`define CCI_SDA_BASE_NS 250
`define CCI_SDA_STEP_NS 50
`define CCI_SDA_BASE_CYC (`CCI_SDA_BASE_NS / `CCI_CLK_PERIOD_NS)
`define CCI_SDA_STEP_CYC (`CCI_SDA_STEP_NS / `CCI_CLK_PERIOD_NS)
`define CCI_WDOG_LONG_S 1
`define CCI_WDOG_LONG_CYC (`CCI_WDOG_LONG_S * `CCI_CLK_HZ)
`define CCI_WDOG_SHORT_US 50
`define CCI_WDOG_SHORT_CYC (`CCI_WDOG_SHORT_US * (`CCI_CLK_HZ / 1000000))
`define CCI_RECOV_HALF_US 5
`define CCI_RECOV_HALF_CYC (`CCI_RECOV_HALF_US * (`CCI_CLK_HZ / 1000000))
`define CCI_RECOV_PULSES 4'h9

`endif

// *** cci_pkg.sv ***
package cci_pkg;
    typedef enum logic [2:0] {
        CCI_WD_WATCH = 3'b001,
        CCI_WD_FREE = 3'b010,
        CCI_WD_RECOVER = 3'b100
    } cci_wdog_state_e;
    typedef logic [6:0] cci_i2c_addr_t;
endpackage

// *** cci_remap_entry.sv ***
`timescale 1ns/100ps
`include "cci_consts.svh"
module cci_remap_entry (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic wr_alias,
    input wire logic wr_phys,
    input wire cci_pkg::cci_i2c_addr_t wdata,
    input wire cci_pkg::cci_i2c_addr_t xact_addr,
    output cci_pkg::cci_i2c_addr_t alias_addr,
    output cci_pkg::cci_i2c_addr_t phys_addr,
    output logic hit
);
    import cci_pkg::*;

    cci_i2c_addr_t alias_reg;
    cci_i2c_addr_t phys_reg;

    assign hit = (xact_addr == alias_reg);
    assign alias_addr = alias_reg;
    assign phys_addr = phys_reg;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            alias_reg <= `CCI_ADDR_RST;
            phys_reg <= `CCI_ADDR_RST;
        end else begin
            if (wr_alias) begin
                alias_reg <= wdata;
            end
            if (wr_phys) begin
                phys_reg <= wdata;
            end
        end
    end
endmodule

// *** cci_far_end.sv ***
`timescale 1ns/100ps
// Far side of the pins: local host on an open-drain bus with pull-ups.
module cci_far_end (
    input wire logic sda_oe,
    input wire logic scl_oe,
    input wire logic host_sda_low,
    input wire logic host_scl_low,
    output logic sda_in,
    output logic scl_in
);
    // The pull-ups give a high idle level, and any party pulling low wins.
    assign sda_in = !(sda_oe || host_sda_low);
    assign scl_in = !(scl_oe || host_scl_low);
endmodule

// *** tb.sv ***
`timescale 1ns/100ps
module tb;
    import cci_pkg::*;
    localparam int LONG = 200;
    localparam int SHORT = 20;
    localparam int HALF = 4;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr_en = 1'b0;
    logic reg_wr_remote = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_wr_rejected;
    logic fwd_seq_err_det = 1'b0;
    logic remote_serializer_identifier_load = 1'b0;
    cci_i2c_addr_t remote_serializer_identifier_in = 7'h00;
    logic xact_addr_valid = 1'b0;
    cci_i2c_addr_t xact_addr = 7'h00;
    logic cc_addr_valid;
    cci_i2c_addr_t cc_addr;
    logic sda_drive_req = 1'b0;
    logic sda_in, sda_oe, scl_in, scl_oe, bus_free, bus_recovering;
    logic sda_o, scl_o;
    logic host_sda_low = 1'b0;
    logic host_scl_low = 1'b0;
    int num_errors = 0;
    int n_compared = 0;
    int seed = 44;
    int n, cnt;
    logic [7:0] d;
    logic rej, prev;
    cci_i2c_addr_t al0, al1, ph0, ph1, a, rid;

    always #25 clk_sys = ~clk_sys;

    cci_config #(.WDOG_LONG_CYC(LONG), .WDOG_SHORT_CYC(SHORT), .RECOV_HALF_CYC(HALF)) dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en), .reg_wr_remote(reg_wr_remote),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_wr_rejected(reg_wr_rejected), .fwd_seq_err_det(fwd_seq_err_det),
        .remote_serializer_identifier_load(remote_serializer_identifier_load), .remote_serializer_identifier_in(remote_serializer_identifier_in), .xact_addr_valid(xact_addr_valid),
        .xact_addr(xact_addr), .cc_addr_valid(cc_addr_valid), .cc_addr(cc_addr),
        .sda_drive_req(sda_drive_req), .sda_in(sda_in), .sda_out(sda_o), .sda_oe(sda_oe), .scl_in(scl_in),
        .scl_out(scl_o), .scl_oe(scl_oe), .bus_free(bus_free), .bus_recovering(bus_recovering));

    cci_far_end far (.sda_oe(sda_oe), .scl_oe(scl_oe), .host_sda_low(host_sda_low),
        .host_scl_low(host_scl_low), .sda_in(sda_in), .scl_in(scl_in));

    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #5;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] wd, input logic rem);
        reg_wr_en = 1'b1;
        reg_addr = ad;
        reg_wdata = wd;
        reg_wr_remote = rem;
        tick(1);
        rej = reg_wr_rejected;
        reg_wr_en = 1'b0;
        reg_wr_remote = 1'b0;
        tick(1);
    endtask

    task automatic rdchk(input logic [7:0] ad, input logic [7:0] exp);
        reg_rd_en = 1'b1;
        reg_addr = ad;
        tick(1);
        chk(reg_rdata, exp);
        reg_rd_en = 1'b0;
        tick(1);
    endtask

    // Host toggles SCL so the watchdog sees activity.
    task automatic bump;
        host_scl_low = 1'b1;
        tick(2);
        host_scl_low = 1'b0;
        tick(1);
    endtask

    task automatic wait_sig(input bit rec, input int lo, input int hi);
        n = 0;
        while (((rec ? bus_recovering : bus_free) !== 1'b1) && n < hi + 2) begin
            tick(1);
            n++;
        end
        chk(8'(n >= lo && n <= hi), 8'h01);
    endtask

    task automatic pulse_id(input cci_i2c_addr_t id);
        remote_serializer_identifier_load = 1'b1;
        remote_serializer_identifier_in = id;
        tick(1);
        remote_serializer_identifier_load = 1'b0;
    endtask

    function automatic cci_i2c_addr_t exp_map(input cci_i2c_addr_t x);
        if (x === al0) return ph0;
        if (x === al1) return ph1;
        return x;
    endfunction

    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        num_errors++;
        $display("watchdog ran out");
        print_verdict;
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        #5;
        sys_rst = 1'b0;
        for (int i = 6; i < 10; i++) begin
            rdchk(8'(i), 8'h00);
        end
        rdchk(8'h20, 8'h00);
        wr(8'h06, 8'hFF, 1'b0);
        rdchk(8'h06, 8'h5F);
        wr(8'h08, 8'hFF, 1'b0);
        rdchk(8'h08, 8'hFE);
        wr(8'h07, 8'hFE, 1'b0);
        rdchk(8'h07, 8'h00);
        $display("done: reset and reserved");
        wr(8'h06, 8'h01, 1'b0);
        fwd_seq_err_det = 1'b1;
        tick(1);
        fwd_seq_err_det = 1'b0;
        tick(10);
        rdchk(8'h06, 8'h81);
        wr(8'h06, 8'h41, 1'b0);
        rdchk(8'h06, 8'h41);
        wr(8'h06, 8'h01, 1'b0);
        rdchk(8'h06, 8'h01);
        $display("done: sequence error");
        for (int f = 0; f < 4; f++) begin
            wr(8'h06, 8'(f * 8 + 1), 1'b0);
            sda_drive_req = 1'b1;
            n = 0;
            do begin
                tick(1);
                n++;
            end while (sda_oe !== 1'b1 && n < 20);
            chk(8'(n), 8'(5 + f));
            chk({7'h00, sda_o}, 8'h00);
            sda_drive_req = 1'b0;
            tick(12);
        end
        $display("done: sda delay");
        wr(8'h06, 8'h05, 1'b0);
        wr(8'h08, 8'h22, 1'b1);
        chk(8'(rej), 8'h01);
        rdchk(8'h08, 8'hFE);
        wr(8'h06, 8'h00, 1'b1);
        rdchk(8'h06, 8'h05);
        for (int k = 0; k < 3; k++) begin
            al0 = 7'($random(seed));
            al1 = (k == 2) ? al0 : 7'(al0 + 7'h01);
            ph0 = 7'($random(seed));
            ph1 = 7'($random(seed));
            wr(8'h10, {al0, 1'b1}, 1'b0);
            wr(8'h11, {al1, 1'b1}, 1'b0);
            wr(8'h08, {ph0, 1'b1}, 1'b0);
            wr(8'h09, {ph1, 1'b1}, 1'b0);
            rdchk(8'h09, {ph1, 1'b0});
            rdchk(8'h10, {al0, 1'b0});
            rdchk(8'h11, {al1, 1'b0});
            for (int j = 0; j < 6; j++) begin
                a = (j == 0) ? al0 : (j == 1) ? al1 : 7'($random(seed));
                xact_addr_valid = 1'b1;
                xact_addr = a;
                tick(1);
                chk(8'(cc_addr_valid), 8'h01);
                chk({1'b0, cc_addr}, {1'b0, exp_map(a)});
                xact_addr_valid = 1'b0;
                tick(1);
            end
        end
        wr(8'h06, 8'h01, 1'b0);
        wr(8'h08, 8'h22, 1'b1);
        chk(8'(rej), 8'h00);
        rdchk(8'h08, 8'h22);
        $display("done: remap and write block");
        rid = 7'($random(seed));
        pulse_id(rid);
        rdchk(8'h07, {rid, 1'b0});
        wr(8'h07, 8'hA7, 1'b0);
        rdchk(8'h07, 8'hA7);
        pulse_id(~rid);
        rdchk(8'h07, 8'hA7);
        wr(8'h07, 8'h00, 1'b0);
        pulse_id(~rid);
        rdchk(8'h07, {~rid, 1'b0});
        $display("done: identifier");
        wr(8'h06, 8'h02, 1'b0);
        bump;
        wait_sig(1'b0, SHORT, SHORT + 8);
        wr(8'h06, 8'h03, 1'b0);
        tick(SHORT * 3);
        chk(8'(bus_free), 8'h00);
        wr(8'h06, 8'h00, 1'b0);
        bump;
        wait_sig(1'b0, LONG, LONG + 8);
        wr(8'h06, 8'h02, 1'b0);
        host_sda_low = 1'b1;
        bump;
        wait_sig(1'b1, SHORT, SHORT + 8);
        chk({6'h00, scl_oe, scl_o}, 8'h02);
        cnt = 0;
        n = 0;
        while (bus_recovering === 1'b1 && n < 200) begin
            prev = scl_oe;
            tick(1);
            n++;
            cnt += (prev === 1'b1 && scl_oe === 1'b0) ? 1 : 0;
        end
        chk(8'(cnt), 8'h09);
        bump;
        wait_sig(1'b1, SHORT, SHORT + 8);
        wr(8'h06, 8'h03, 1'b0);
        chk({6'h00, bus_recovering, scl_oe}, 8'h00);
        host_sda_low = 1'b0;
        $display("done: watchdog");
        print_verdict;
    end
endmodule
